// [verilog/dac_loader_pkg.sv]
// constants, types and register map of the serial converter loader
// Notes on behaviour
// - each frame is exactly eighteen bits
// - address 0 selects channel 0, 15 selects 15
// - mode 00 loads payload and starts conversion
// - busy low during conversion, input ignored
// - conversion lasts typically 25 microseconds
// - mode 01 adds, 10 subtracts quarter steps
// - step size up to 4095 quarter steps
// - step takes about 1 us, busy high
// - mode 11 changes nothing
// - frame select fall clears bit counter
// - data accepted only while frame select low
// - standalone: transfer after 18th falling edge
// - early frame select rise aborts transfer
// - chained: shift on every clock while low
// - chained: excess bits leave on rising edge
// - chained: frame select rise transfers frame
// - channel codes are offset binary 0..4095
// - power-on sets channels to reset value
// - reset pulse restores power-on condition
package dac_loader_pkg;

  localparam int CLK_PERIOD_NS = 40;

  // frame layout
  localparam int FRAME_LEN   = 18;
  localparam int MODE_MSB    = 17;
  localparam int MODE_LSB    = 16;
  localparam int ADDR_MSB    = 15;
  localparam int ADDR_LSB    = 12;
  localparam int PAYLOAD_W   = 12;
  localparam int CH_ADDR_W   = 4;
  localparam int NUM_CH      = 16;
  localparam int FRAC_W      = 2;
  localparam int VAL_W       = PAYLOAD_W + FRAC_W;
  localparam int BIT_CNT_W   = 5;

  // timing figures in nanoseconds
  localparam int CONV_TIME_NS = 25000;
  localparam int STEP_TIME_NS = 1000;

  // channel reset code: midscale, fraction zero
  localparam logic [PAYLOAD_W-1:0] RESET_CODE = 12'h800;

  // register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LAST   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CHAN0  = 8'h40;
  localparam int CHAN_IDX_LSB = 2;

  // field positions
  localparam int CTRL_CHAIN_BIT  = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_STEP_BIT   = 1;
  localparam int STAT_ARMED_BIT  = 2;
  localparam int STAT_CNT_LSB    = 8;

  typedef enum logic [1:0] {
    MODE_LOAD = 2'h0,
    MODE_INC  = 2'h1,
    MODE_DEC  = 2'h2,
    MODE_NOP  = 2'h3
  } mode_t;

  typedef enum logic {
    ST_IDLE = 1'h0,
    ST_CONV = 1'h1
  } st_t;

  // typical figure rounded up to whole cycles, never below one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

endpackage

// [verilog/dac_loader.sv]
// serial command loader for sixteen channel registers, apb status access
`timescale 1ns/100ps
module dac_loader
  import dac_loader_pkg::*;
#(
  parameter int CONV_NS = CONV_TIME_NS,
  parameter int STEP_NS = STEP_TIME_NS
) (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic [31:0]               pwdata,
  output      logic [31:0]               prdata,
  output      logic                      pready,
  output      logic                      pslverr,
  // serial link
  input  wire logic                      frame_select_n,
  input  wire logic                      shift_clk,
  input  wire logic                      serial_in,
  output      logic                      serial_out,
  output      logic                      busy_n,
  // channel codes, channel i at bits i*VAL_W
  output      logic [NUM_CH*VAL_W-1:0]   chan_value
);

  localparam int CONV_CYC = ns_to_cycles(CONV_NS);
  localparam int STEP_CYC = ns_to_cycles(STEP_NS);
  localparam int CONV_W   = $clog2(CONV_CYC + 1);
  localparam int STEP_W   = $clog2(STEP_CYC + 1);
  localparam int PAD_W    = VAL_W + 1 - PAYLOAD_W;

  typedef struct packed {
    st_t                              st;
    logic [CONV_W-1:0]                conv_cnt;
    logic [STEP_W-1:0]                step_cnt;
    logic                             fs_q;
    logic                             sck_q;
    logic                             armed;
    logic [BIT_CNT_W-1:0]             bit_cnt;
    logic [FRAME_LEN-1:0]             shreg;
    logic                             sout;
    logic                             chain_en;
    logic [FRAME_LEN-1:0]             last_frame;
    logic [NUM_CH-1:0][VAL_W-1:0]     chan;
    logic [31:0]                      rdata;
    logic                             slverr;
  } state_t;

  state_t r;
  state_t n;

  logic                   fs_fall;
  logic                   fs_rise;
  logic                   sck_fall;
  logic                   sck_rise;
  logic                   commit;
  logic [FRAME_LEN-1:0]   cf;
  mode_t                  cf_mode;
  logic [CH_ADDR_W-1:0]   cf_addr;
  logic [PAYLOAD_W-1:0]   cf_payload;
  logic [31:0]            rd_val;
  logic                   rd_err;
  logic                   chan_hit;
  logic [CH_ADDR_W-1:0]   chan_idx;

  // saturating add or subtract of quarter-lsb steps
  function automatic logic [VAL_W-1:0] step_val(
    input logic [VAL_W-1:0]     v,
    input logic [PAYLOAD_W-1:0] d,
    input logic                 up
  );
    logic [VAL_W:0] s;
    s = {1'h0, v};
    if (up) begin
      s = {1'h0, v} + {{PAD_W{1'h0}}, d};
      if (s[VAL_W]) begin
        s = {1'h0, {VAL_W{1'h1}}};
      end
    end else begin
      s = {1'h0, v} - {{PAD_W{1'h0}}, d};
      if (s[VAL_W]) begin
        s = '0;
      end
    end
    return s[VAL_W-1:0];
  endfunction

  // inputs are synchronous to pclk, edges found against last sample
  assign fs_fall  = r.fs_q & ~frame_select_n;
  assign fs_rise  = ~r.fs_q & frame_select_n;
  assign sck_fall = r.sck_q & ~shift_clk;
  assign sck_rise = ~r.sck_q & shift_clk;

  // frame fields, mode first then address then payload
  assign cf_mode    = mode_t'(cf[MODE_MSB:MODE_LSB]);
  assign cf_addr    = cf[ADDR_MSB:ADDR_LSB];
  assign cf_payload = cf[PAYLOAD_W-1:0];

  // apb read decode
  assign chan_hit = (paddr >= REG_CHAN0) &&
                    (paddr < ADDR_W'(REG_CHAN0 + NUM_CH * 4)) &&
                    (paddr[CHAN_IDX_LSB-1:0] == '0);
  assign chan_idx = paddr[CHAN_IDX_LSB +: CH_ADDR_W];

  always_comb begin
    rd_val = '0;
    rd_err = 1'h0;
    if (paddr == REG_CTRL) begin
      rd_val[CTRL_CHAIN_BIT] = r.chain_en;
    end else if (paddr == REG_STATUS) begin
      rd_val[STAT_BUSY_BIT]  = (r.st == ST_CONV);
      rd_val[STAT_STEP_BIT]  = (r.step_cnt != '0);
      rd_val[STAT_ARMED_BIT] = r.armed;
      rd_val[STAT_CNT_LSB +: BIT_CNT_W] = r.bit_cnt;
    end else if (paddr == REG_LAST) begin
      rd_val[FRAME_LEN-1:0] = r.last_frame;
    end else if (chan_hit) begin
      rd_val[VAL_W-1:0] = r.chan[chan_idx];
    end else begin
      rd_err = 1'h1;
    end
  end

  // transfer decision kept apart so field decode feeds the state update
  always_comb begin
    commit = 1'h0;
    cf     = r.shreg;
    if (r.st == ST_IDLE && r.armed && !fs_fall) begin
      if (fs_rise) begin
        // chained: a full frame must have been counted
        commit = r.chain_en &&
                 (r.bit_cnt == BIT_CNT_W'(FRAME_LEN));
      end else if (!frame_select_n && sck_fall && !r.chain_en &&
                   r.bit_cnt == BIT_CNT_W'(FRAME_LEN - 1)) begin
        commit = 1'h1;
        cf     = {r.shreg[FRAME_LEN-2:0], serial_in};
      end
    end
  end

  always_comb begin
    n        = r;
    n.fs_q   = frame_select_n;
    n.sck_q  = shift_clk;

    // read data captured in setup so the access phase needs no wait
    if (psel && !penable) begin
      n.rdata  = rd_val;
      n.slverr = rd_err;
    end
    if (psel && penable && pwrite && paddr == REG_CTRL) begin
      n.chain_en = pwdata[CTRL_CHAIN_BIT];
    end

    if (r.step_cnt != '0) begin
      n.step_cnt = r.step_cnt - STEP_W'(1);
    end

    case (r.st)
      ST_IDLE: begin
        if (sck_rise) begin
          n.sout = r.shreg[FRAME_LEN-1];
        end
        if (fs_fall) begin
          n.armed   = 1'h1;
          n.bit_cnt = '0;
        end else if (r.armed) begin
          if (fs_rise) begin
            n.armed = 1'h0;
          end else if (!frame_select_n && sck_fall) begin
            n.shreg = {r.shreg[FRAME_LEN-2:0], serial_in};
            if (r.bit_cnt != BIT_CNT_W'(FRAME_LEN)) begin
              n.bit_cnt = r.bit_cnt + BIT_CNT_W'(1);
            end
            // standalone stops at the 18th edge; chained keeps going
            if (commit) begin
              n.armed = 1'h0;
            end
          end
        end

        if (commit) begin
          n.last_frame = cf;
          case (cf_mode)
            MODE_LOAD: begin
              n.chan[cf_addr] = {cf_payload, {FRAC_W{1'h0}}};
              n.st       = ST_CONV;
              n.conv_cnt = CONV_W'(CONV_CYC - 1);
              n.armed    = 1'h0;
            end
            MODE_INC: begin
              n.chan[cf_addr] = step_val(r.chan[cf_addr], cf_payload,
                                         1'h1);
              n.step_cnt = STEP_W'(STEP_CYC);
            end
            MODE_DEC: begin
              n.chan[cf_addr] = step_val(r.chan[cf_addr], cf_payload,
                                         1'h0);
              n.step_cnt = STEP_W'(STEP_CYC);
            end
            default: begin
            end
          endcase
        end
      end
      ST_CONV: begin
        // every shift clock and frame edge is dropped while busy
        n.armed = 1'h0;
        if (r.conv_cnt == '0) begin
          n.st = ST_IDLE;
        end else begin
          n.conv_cnt = r.conv_cnt - CONV_W'(1);
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.st      <= ST_IDLE;
      r.fs_q    <= 1'h1;
      r.chan    <= {NUM_CH{RESET_CODE, {FRAC_W{1'h0}}}};
    end else begin
      r <= n;
    end
  end

  assign prdata     = r.rdata;
  assign pslverr    = r.slverr;
  assign pready     = 1'h1;
  assign serial_out = r.sout;
  assign busy_n     = (r.st != ST_CONV);
  assign chan_value = r.chan;

  // busy-low length counter, read only by the checks below
  logic [CONV_W:0] low_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_len <= '0;
    end else if (!busy_n) begin
      low_len <= low_len + (CONV_W + 1)'(1);
    end else begin
      low_len <= '0;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_busy_low_len: assert property ($rose(busy_n) |->
      low_len == (CONV_W + 1)'(CONV_CYC))
    else $error("busy low time differs from conversion time");

  chk_load_code: assert property (commit && cf_mode == MODE_LOAD |=>
      (r.chan[$past(cf_addr)] ==
       {$past(cf_payload), {FRAC_W{1'h0}}}) && !busy_n)
    else $error("direct load did not store code or raise busy");

  chk_busy_ignores: assert property (!busy_n |=>
      !r.armed && $stable(r.shreg) && $stable(r.chan))
    else $error("serial input acted on during conversion");

  chk_nop_stable: assert property (commit && cf_mode == MODE_NOP |=>
      $stable(r.chan) && busy_n)
    else $error("no-operation frame changed a channel");

  chk_step_busy_hi: assert property (commit &&
      (cf_mode == MODE_INC || cf_mode == MODE_DEC) |=>
      busy_n [*8])
    else $error("busy dropped during a step adjustment");

  chk_inc_dir: assert property (commit && cf_mode == MODE_INC |=>
      r.chan[$past(cf_addr)] >= $past(r.chan[cf_addr]))
    else $error("increment lowered the channel value");

  chk_fs_clears: assert property (fs_fall && r.st == ST_IDLE |=>
      r.bit_cnt == '0 && r.armed)
    else $error("frame select fall did not clear the counter");

  chk_early_abort: assert property (!r.chain_en && r.armed &&
      fs_rise && r.st == ST_IDLE |=>
      $stable(r.chan) && !r.armed && busy_n)
    else $error("early frame select rise updated a channel");

  chk_sa_commit: assert property (!r.chain_en && r.armed &&
      r.st == ST_IDLE && !frame_select_n && sck_fall && !fs_fall &&
      r.bit_cnt == BIT_CNT_W'(FRAME_LEN - 1) |-> commit)
    else $error("18th falling edge did not transfer the frame");

  chk_sout_edge: assert property (sck_rise && r.st == ST_IDLE |=>
      serial_out == $past(r.shreg[FRAME_LEN-1]))
    else $error("serial output not updated on rising edge");

  chk_chain_commit: assert property (r.chain_en && r.armed &&
      r.st == ST_IDLE && fs_rise &&
      r.bit_cnt == BIT_CNT_W'(FRAME_LEN) |-> commit)
    else $error("chained frame not transferred on rise");

  chk_dec_dir: assert property (commit && cf_mode == MODE_DEC |=>
      r.chan[$past(cf_addr)] <= $past(r.chan[cf_addr]))
    else $error("decrement raised the channel value");

  chk_step_status: assert property (commit &&
      (cf_mode == MODE_INC || cf_mode == MODE_DEC) |=>
      r.step_cnt == STEP_W'(STEP_CYC) && busy_n)
    else $error("step adjustment did not start its timer");

  chk_chain_no_edge: assert property (r.chain_en && !fs_rise |->
      !commit)
    else $error("chained frame transferred without frame end");

  chk_sa_no_rise: assert property (!r.chain_en && fs_rise |->
      !commit)
    else $error("standalone frame transferred on frame end");

  chk_short_chain: assert property (r.chain_en && fs_rise &&
      r.bit_cnt != BIT_CNT_W'(FRAME_LEN) |-> !commit)
    else $error("short chained frame was transferred");

  chk_idle_no_shift: assert property (frame_select_n |=>
      $stable(r.shreg))
    else $error("data shifted while frame select high");

  chk_chain_shift: assert property (r.chain_en && r.armed &&
      r.st == ST_IDLE && !fs_fall && !frame_select_n && sck_fall |=>
      r.shreg == {$past(r.shreg[FRAME_LEN-2:0]), $past(serial_in)})
    else $error("chained shift register did not shift");

  chk_ctrl_write: assert property (psel && penable && pwrite &&
      paddr == REG_CTRL |=> r.chain_en == $past(pwdata[CTRL_CHAIN_BIT]))
    else $error("chain enable write not taken");

  chk_bitcnt_max: assert property (
      r.bit_cnt <= BIT_CNT_W'(FRAME_LEN))
    else $error("bit counter ran past a frame");

  chk_commit_idle: assert property (commit |->
      r.st == ST_IDLE)
    else $error("frame transferred during a conversion");

  chk_sout_hold: assert property (!sck_rise |=>
      $stable(serial_out))
    else $error("serial output moved without a rising edge");

  chk_sa_stop: assert property (!r.chain_en && !r.armed &&
      !fs_fall |=> $stable(r.bit_cnt))
    else $error("bit counter moved after the frame ended");

endmodule

// [verification/serial_host.sv]
// serial master model that drives command frames into the loader
`timescale 1ns/100ps
module serial_host (
  // clock
  input  wire logic pclk,
  // serial link
  output      logic frame_select_n,
  output      logic shift_clk,
  output      logic serial_in,
  input  wire logic serial_out,
  input  wire logic busy_n
);
  logic dout_seen [0:63];

  // shift clock idles low and only runs inside a frame
  // early skips the busy wait to show a frame begun in a conversion is lost
  task automatic send(input logic [35:0] bits, input int n, input bit early);
    while (!early && busy_n !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    frame_select_n <= 1'b0;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      serial_in <= bits[n-1-i];
      shift_clk <= 1'b1;
      repeat (3) @(posedge pclk);
      dout_seen[i] = serial_out;
      shift_clk <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    frame_select_n <= 1'b1;
    // a released data line must not keep showing the last bit
    serial_in <= ~serial_in;
    repeat (12) @(posedge pclk);
  endtask

  initial begin
    frame_select_n = 1'b1;
    shift_clk = 1'b0;
    serial_in = 1'b0;
  end
endmodule

// [verification/test_dac_loader.sv]
// self-checking testbench of the serial converter loader
`timescale 1ns/100ps
module test_dac_loader;
  import dac_loader_pkg::*;
  localparam int CONV_CYC = 2000 / CLK_PERIOD_NS;
  logic                    pclk, presetn, psel, penable, pwrite;
  logic                    pready, pslverr, err, busy_n;
  logic                    frame_select_n, shift_clk, serial_in, serial_out;
  logic [ADDR_W-1:0]       paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic [NUM_CH*VAL_W-1:0] chan_value;
  logic [VAL_W-1:0]        expv [NUM_CH];
  int                      fails, check_count, low_base;
  int                      low_cnt = 0;
  integer                  seed;

  dac_loader #(.CONV_NS(2000), .STEP_NS(200)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_select_n(frame_select_n),
    .shift_clk(shift_clk), .serial_in(serial_in), .serial_out(serial_out),
    .busy_n(busy_n), .chan_value(chan_value));
  serial_host host (
    .pclk(pclk), .frame_select_n(frame_select_n), .shift_clk(shift_clk),
    .serial_in(serial_in), .serial_out(serial_out), .busy_n(busy_n));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (busy_n === 1'b0) low_cnt <= low_cnt + 1;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_all();
    for (int c = 0; c < NUM_CH; c++)
      check("channel", {18'h0, chan_value[c*VAL_W +: VAL_W]},
            {18'h0, expv[c]});
  endtask
  // quarter-step adjust that saturates at both ends of the fine scale
  function automatic logic [VAL_W-1:0] sat(input logic [VAL_W-1:0] v,
                                           input logic [11:0] d,
                                           input logic up);
    logic [VAL_W:0] s;
    s = up ? {1'b0, v} + d : {1'b0, v} - d;
    if (s[VAL_W]) s = up ? {1'b0, {VAL_W{1'b1}}} : '0;
    return s[VAL_W-1:0];
  endfunction
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed: only the watchdog ends a hung access
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [1:0] m, input logic [3:0] ch,
                    input logic [11:0] d, input logic chain);
    logic [35:0] b;
    b = {18'($random(seed)), m, ch, d};
    low_base = low_cnt;
    host.send(b, chain ? 36 : 18, 1'b0);
    for (int k = 0; k < 200 && busy_n !== 1'b1; k++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    case (m)
      2'h0: expv[ch] = {d, 2'h0};
      2'h1: expv[ch] = sat(expv[ch], d, 1'b1);
      2'h2: expv[ch] = sat(expv[ch], d, 1'b0);
      default: ;
    endcase
    check("busy low", low_cnt - low_base,
          (m == 2'h0) ? CONV_CYC : 0);
    check_all();
    apb(1'b0, REG_LAST, 32'h0);
    check("last frame", rd, {14'h0, m, ch, d});
    apb(1'b0, ADDR_W'(REG_CHAN0 + 4 * ch), 32'h0);
    check("channel reg", rd, {18'h0, expv[ch]});
    if (chain)
      for (int i = 18; i < 36; i++)
        check("serial out", host.dout_seen[i], b[53-i]);
  endtask
  task automatic abort_at(input int n);
    low_base = low_cnt;
    host.send({4'h0, 32'($random(seed))}, n, 1'b0);
    check("busy low", low_cnt - low_base, 0);
    check_all();
    apb(1'b0, REG_STATUS, 32'h0);
    check("status", rd, 32'(n) << STAT_CNT_LSB);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(40 * 60000);
    fails++;
    print_verdict();
  end

  initial begin
    seed = 32'hfc6d2c29;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fails, check_count} = '0;
    for (int c = 0; c < NUM_CH; c++) expv[c] = 14'h2000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_all();
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b1, 8'h30, 32'hffff_ffff);
    check("unmapped error", {31'h0, err}, 32'h1);
    $display("reset and register test done");
    // corner codes: both ends of channel, code and fine range
    op(2'h0, 4'h0, 12'h000, 1'b0);
    op(2'h2, 4'h0, 12'h001, 1'b0);
    op(2'h0, 4'hf, 12'hfff, 1'b0);
    op(2'h1, 4'hf, 12'hfff, 1'b0);
    op(2'h1, 4'h3, 12'h001, 1'b0);
    op(2'h2, 4'h3, 12'h00a, 1'b0);
    op(2'h3, 4'h3, 12'h123, 1'b0);
    for (int i = 0; i < 12; i++)
      op(2'($random(seed)), 4'($random(seed)), 12'($random(seed)), 1'b0);
    abort_at(17);
    abort_at(1);
    // a frame begun during a conversion is dropped whole
    low_base = low_cnt;
    host.send({18'h0, 2'h0, 4'h6, 12'h3c3}, 18, 1'b0);
    host.send({18'h0, 2'h0, 4'h6, 12'h0f0}, 18, 1'b1);
    expv[6] = {12'h3c3, 2'h0};
    check("busy low", low_cnt - low_base, CONV_CYC);
    check_all();
    $display("standalone test done");
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl chain", rd, 32'h1);
    for (int m = 0; m < 4; m++)
      op(2'(m), 4'($random(seed)), 12'($random(seed)), 1'b1);
    abort_at(10);
    $display("chained test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < NUM_CH; c++) expv[c] = 14'h2000;
    @(posedge pclk);
    check_all();
    check("serial out reset", {31'h0, serial_out}, 32'h0);
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl after reset", rd, 32'h0);
    $display("mid-run reset test done");
    print_verdict();
  end
endmodule
